// file: verilog/pwr_seq_map.svh
// constants for the button power and reset sequencer
`ifndef PWR_SEQ_MAP_SVH
`define PWR_SEQ_MAP_SVH
`define CLK_HZ 100000000
`define HOLD_QUAL_MS 1000
`define HOLD_WAKE_MS 3000
`define HOLD_FULL_MS 5000
`define PULSE_WIDTH_DEF 16'h0064
`define CNT_W 32
`endif

// file: verilog/pwr_seq_pkg.sv
// types for the button power and reset sequencer
`default_nettype none
package pwr_seq_pkg;
  typedef enum logic [1:0] {
    st_s0,
    st_s3,
    st_s4,
    st_s5
  } pwr_state_t;
  typedef enum logic [1:0] {
    sleep_req_none,
    sleep_req_s3,
    sleep_req_s4,
    sleep_req_s5
  } sleep_req_t;
endpackage : pwr_seq_pkg
`default_nettype wire

// file: verilog/hold_timer.sv
// synchroniser and hold-time counter for one push button
`default_nettype none
`include "pwr_seq_map.svh"
module hold_timer (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic btn_raw,
  output logic btn_level,
  output logic [`CNT_W-1:0] held_cycles,
  output logic released
);
  logic sync_a;
  logic sync_b;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= btn_raw;
      sync_b <= sync_a;
    end
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      btn_level <= 1'b0;
      held_cycles <= '0;
      released <= 1'b0;
    end else begin
      btn_level <= sync_b;
      released <= btn_level && !sync_b;
      if (!sync_b)
        held_cycles <= '0;
      else if (held_cycles != {`CNT_W{1'b1}})
        held_cycles <= held_cycles + `CNT_W'(1);
    end
  end
endmodule : hold_timer
`default_nettype wire

// file: verilog/pulse_gen.sv
// programmable width pulse generator for reset outputs
`default_nettype none
module pulse_gen (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic fire,
  input wire logic [15:0] width,
  output logic pulse
);
  logic [15:0] left;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      left <= 16'h0000;
      pulse <= 1'b0;
    end else if (fire && left == 16'h0000) begin
      left <= (width == 16'h0000) ? 16'h0001 : width;
      pulse <= 1'b1;
    end else if (left > 16'h0001) begin
      left <= left - 16'h0001;
    end else begin
      left <= 16'h0000;
      pulse <= 1'b0;
    end
  end
endmodule : pulse_gen
`default_nettype wire

// file: verilog/button_power_reset_sequencer.sv
// push-button power state and reset sequencer top level
// What this block does
// - track power states S0, S3, S4, S5
// - leave S0 on software or button request
// - wake from any standby after 3 s hold
// - usb wake only in S3 or S4
// - usb wake needs device attached whole sleep
// - power button acts only after >1 s hold
// - button: on when off, configured sleep, wake
// - reset held 1..5 s: module-only reset
// - reset held >=5 s: full reset on release
// - reset press under 1 s is ignored
`default_nettype none
`include "pwr_seq_map.svh"
module button_power_reset_sequencer
  import pwr_seq_pkg::*;
#(
  parameter int unsigned QUAL_CYC =
    `CLK_HZ / 1000 * `HOLD_QUAL_MS,
  parameter int unsigned WAKE_CYC =
    `CLK_HZ / 1000 * `HOLD_WAKE_MS,
  parameter int unsigned FULL_CYC =
    `CLK_HZ / 1000 * `HOLD_FULL_MS
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic power_button,
  input wire logic dual_stage_reset_switch,
  input wire pwr_seq_pkg::sleep_req_t sw_sleep_req,
  input wire pwr_seq_pkg::sleep_req_t button_sleep_cfg,
  input wire logic usb_wake,
  input wire logic usb_attached,
  input wire logic [15:0] reset_pulse_width,
  output pwr_seq_pkg::pwr_state_t power_state,
  output logic system_on,
  output logic module_reset,
  output logic system_reset
);
  import pwr_seq_pkg::*;

  logic pb_level;
  logic [`CNT_W-1:0] pb_held;
  logic rb_level;
  logic [`CNT_W-1:0] rb_held;
  logic rb_released;
  logic pb_armed;
  logic pb_qual;
  logic usb_ok;
  logic usb_armed;
  logic fire_module;
  logic fire_full;
  logic [`CNT_W-1:0] rb_last;

  hold_timer u_pb (
    .mclk(mclk),
    .nrst(nrst),
    .btn_raw(power_button),
    .btn_level(pb_level),
    .held_cycles(pb_held),
    .released()
  );

  hold_timer u_rb (
    .mclk(mclk),
    .nrst(nrst),
    .btn_raw(dual_stage_reset_switch),
    .btn_level(rb_level),
    .held_cycles(rb_held),
    .released(rb_released)
  );

  function automatic logic is_asleep(input pwr_state_t s);
    return s == st_s3 || s == st_s4;
  endfunction : is_asleep

  // threshold per state: longer hold needed to wake
  function automatic logic [`CNT_W-1:0] pb_need(input pwr_state_t s);
    return (s == st_s0) ? `CNT_W'(QUAL_CYC) : `CNT_W'(WAKE_CYC);
  endfunction : pb_need

  // one action per press, fires once threshold exceeded
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pb_armed <= 1'b1;
      pb_qual <= 1'b0;
    end else begin
      pb_qual <= 1'b0;
      if (!pb_level)
        pb_armed <= 1'b1;
      else if (pb_armed && pb_held > pb_need(power_state)) begin
        pb_armed <= 1'b0;
        pb_qual <= 1'b1;
      end
    end
  end

  // usb attachment must hold through the whole sleep
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      usb_ok <= 1'b0;
    end else if (power_state == st_s0) begin
      usb_ok <= usb_attached;
    end else if (!usb_attached) begin
      usb_ok <= 1'b0;
    end
  end

  assign usb_armed = usb_ok && usb_attached && usb_wake &&
    is_asleep(power_state);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      power_state <= st_s5;
    end else begin
      case (power_state)
        st_s0: begin
          if (sw_sleep_req != sleep_req_none) begin
            power_state <= pwr_state_t'(sw_sleep_req);
          end else if (pb_qual) begin
            power_state <= (button_sleep_cfg == sleep_req_none) ?
              st_s5 : pwr_state_t'(button_sleep_cfg);
          end
        end
        st_s3, st_s4: begin
          if (pb_qual || usb_armed)
            power_state <= st_s0;
        end
        st_s5: begin
          if (pb_qual)
            power_state <= st_s0;
        end
        default: power_state <= st_s5;
      endcase
    end
  end

  assign system_on = power_state == st_s0;

  // classify reset press at release
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rb_last <= '0;
      fire_module <= 1'b0;
      fire_full <= 1'b0;
    end else begin
      if (rb_level)
        rb_last <= rb_held;
      fire_module <= rb_released && rb_last >= `CNT_W'(QUAL_CYC) &&
        rb_last < `CNT_W'(FULL_CYC);
      fire_full <= rb_released &&
        rb_last >= `CNT_W'(FULL_CYC);
    end
  end

  pulse_gen u_mod_rst (
    .mclk(mclk),
    .nrst(nrst),
    .fire(fire_module),
    .width(reset_pulse_width),
    .pulse(module_reset)
  );

  pulse_gen u_sys_rst (
    .mclk(mclk),
    .nrst(nrst),
    .fire(fire_full),
    .width(reset_pulse_width),
    .pulse(system_reset)
  );

  property p_short_reset_ignored;
    @(posedge mclk) disable iff (!nrst)
      rb_released && rb_last < `CNT_W'(QUAL_CYC) |=> !fire_module && !fire_full;
  endproperty
  a_short_reset_ignored: assert property (p_short_reset_ignored)
    else $error("short reset press produced a reset");

  property p_module_pulse;
    @(posedge mclk) disable iff (!nrst)
      fire_module && !module_reset |=> module_reset;
  endproperty
  a_module_pulse: assert property (p_module_pulse)
    else $error("module reset did not pulse");

  property p_full_pulse;
    @(posedge mclk) disable iff (!nrst)
      fire_full && !system_reset |=> system_reset;
  endproperty
  a_full_pulse: assert property (p_full_pulse)
    else $error("system reset did not pulse");

  property p_full_not_module;
    @(posedge mclk) disable iff (!nrst) fire_full |-> !fire_module;
  endproperty
  a_full_not_module: assert property (p_full_not_module)
    else $error("both reset kinds fired");

  property p_qual_hold;
    @(posedge mclk) disable iff (!nrst)
      pb_qual |-> $past(pb_held) > `CNT_W'(QUAL_CYC);
  endproperty
  a_qual_hold: assert property (p_qual_hold)
    else $error("power button acted before one second");

  property p_usb_only_asleep;
    @(posedge mclk) disable iff (!nrst)
      $past(power_state) == st_s5 && power_state == st_s0 |->
        $past(pb_qual);
  endproperty
  a_usb_only_asleep: assert property (p_usb_only_asleep)
    else $error("left off state without button");

  property p_usb_detach;
    @(posedge mclk) disable iff (!nrst)
      is_asleep(power_state) && !usb_attached |=> !usb_ok;
  endproperty
  a_usb_detach: assert property (p_usb_detach)
    else $error("usb wake kept after detach");

  property p_sw_sleep;
    @(posedge mclk) disable iff (!nrst)
      power_state == st_s0 && sw_sleep_req == sleep_req_s3 |=>
        power_state == st_s3;
  endproperty
  a_sw_sleep: assert property (p_sw_sleep)
    else $error("software sleep request not taken");

  property p_sw_sleep_any;
    @(posedge mclk) disable iff (!nrst)
      power_state == st_s0 && sw_sleep_req != sleep_req_none |=>
        power_state != st_s0;
  endproperty
  a_sw_sleep_any: assert property (p_sw_sleep_any)
    else $error("software request did not leave running state");

  property p_button_sleep;
    @(posedge mclk) disable iff (!nrst)
      power_state == st_s0 && sw_sleep_req == sleep_req_none && pb_qual |=>
        power_state != st_s0;
  endproperty
  a_button_sleep: assert property (p_button_sleep)
    else $error("qualified press did not leave running state");

  property p_button_power_on;
    @(posedge mclk) disable iff (!nrst)
      power_state == st_s5 && pb_qual |=> power_state == st_s0;
  endproperty
  a_button_power_on: assert property (p_button_power_on)
    else $error("qualified press did not power on");

  property p_wake_hold;
    @(posedge mclk) disable iff (!nrst)
      pb_qual && $past(power_state) != st_s0 |->
        $past(pb_held) > `CNT_W'(WAKE_CYC);
  endproperty
  a_wake_hold: assert property (p_wake_hold)
    else $error("wake press acted before its hold time");

  property p_one_action;
    @(posedge mclk) disable iff (!nrst)
      pb_qual |=> !pb_qual;
  endproperty
  a_one_action: assert property (p_one_action)
    else $error("one press gave two actions");

  property p_usb_wake;
    @(posedge mclk) disable iff (!nrst)
      is_asleep(power_state) && usb_ok && usb_attached && usb_wake |=>
        power_state == st_s0;
  endproperty
  a_usb_wake: assert property (p_usb_wake)
    else $error("usb wake not taken while asleep");

  property p_sleep_holds;
    @(posedge mclk) disable iff (!nrst)
      is_asleep(power_state) && !pb_qual && !usb_armed |=>
        $stable(power_state);
  endproperty
  a_sleep_holds: assert property (p_sleep_holds)
    else $error("sleep state left without a wake event");

  property p_module_on_release;
    @(posedge mclk) disable iff (!nrst)
      fire_module |-> $past(rb_released) &&
        $past(rb_last) >= `CNT_W'(QUAL_CYC) &&
        $past(rb_last) < `CNT_W'(FULL_CYC);
  endproperty
  a_module_on_release: assert property (p_module_on_release)
    else $error("module reset without a mid-length press");

  property p_full_on_release;
    @(posedge mclk) disable iff (!nrst)
      fire_full |-> $past(rb_released) &&
        $past(rb_last) >= `CNT_W'(FULL_CYC);
  endproperty
  a_full_on_release: assert property (p_full_on_release)
    else $error("full reset without a long press");

  c_power_on: cover property (@(posedge mclk) disable iff (!nrst)
    $past(power_state) == st_s5 && power_state == st_s0);
  c_usb_wake: cover property (@(posedge mclk) disable iff (!nrst)
    usb_armed);
  c_mod_rst: cover property (@(posedge mclk) disable iff (!nrst)
    fire_module);
  c_full_rst: cover property (@(posedge mclk) disable iff (!nrst)
    fire_full);
  c_btn_sleep: cover property (@(posedge mclk) disable iff (!nrst)
    power_state == st_s0 && pb_qual && sw_sleep_req == sleep_req_none);
endmodule : button_power_reset_sequencer
`default_nettype wire

// file: verification/button_model.sv
// push button model held for a given number of board clocks
`default_nettype none
module button_model (
  input wire logic mclk,
  output logic pressed
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pressed = 1'b0;
  task automatic hold(input int n);
    @(posedge mclk);
    #1 pressed = 1'b1;
    repeat (n) @(posedge mclk);
    #1 pressed = 1'b0;
  endtask : hold
endmodule : button_model
`default_nettype wire

// file: verification/button_power_reset_sequencer_test.sv
// self-checking bench for the button power and reset sequencer
`default_nettype none
module button_power_reset_sequencer_test import pwr_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int Q = 10;
  localparam int W = 30;
  localparam int F = 50;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic power_button, dual_stage_reset_switch, system_on;
  logic usb_wake = 1'b0;
  logic usb_attached = 1'b0;
  logic module_reset, system_reset;
  logic [15:0] reset_pulse_width = 16'h0004;
  logic [15:0] mc, sc;
  logic cnt_clr = 1'b0;
  sleep_req_t sw_sleep_req = sleep_req_none;
  sleep_req_t button_sleep_cfg = sleep_req_s3;
  pwr_state_t power_state;
  int bad_count = 0;
  int comparisons = 0;
  always #5 mclk = ~mclk;
  // reset pulse lengths, cleared by the main sequence
  always @(posedge mclk) begin
    if (cnt_clr) begin
      mc <= 16'h0000;
      sc <= 16'h0000;
    end else begin
      mc <= mc + 16'(module_reset);
      sc <= sc + 16'(system_reset);
    end
  end
  button_model button_model_inst (.mclk(mclk), .pressed(power_button));
  button_model reset_button_model_inst (.mclk(mclk),
    .pressed(dual_stage_reset_switch));
  button_power_reset_sequencer #(.QUAL_CYC(Q), .WAKE_CYC(W), .FULL_CYC(F))
    button_power_reset_sequencer_inst (.mclk(mclk), .nrst(nrst),
    .power_button(power_button),
    .dual_stage_reset_switch(dual_stage_reset_switch),
    .sw_sleep_req(sw_sleep_req), .button_sleep_cfg(button_sleep_cfg),
    .usb_wake(usb_wake), .usb_attached(usb_attached),
    .reset_pulse_width(reset_pulse_width), .power_state(power_state),
    .system_on(system_on), .module_reset(module_reset),
    .system_reset(system_reset));
  function automatic pwr_state_t target(sleep_req_t r);
    return r == sleep_req_s3 ? st_s3 : r == sleep_req_s4 ? st_s4 : st_s5;
  endfunction : target
  function automatic logic [15:0] rst_cyc(int n, int kind, logic [15:0] w);
    if ((n < Q ? 0 : n < F ? 1 : 2) != kind) begin
      return 16'h0000;
    end
    return w == 16'h0000 ? 16'h0001 : w;
  endfunction : rst_cyc
  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic cmp_st(input pwr_state_t exp);
    repeat (8) @(posedge mclk);
    #1 cmp({14'h0000, power_state}, {14'h0000, exp});
    cmp({15'h0000, system_on}, {15'h0000, exp == st_s0});
  endtask : cmp_st
  task automatic sw_go(input sleep_req_t r);
    @(posedge mclk);
    #1 sw_sleep_req = r;
    @(posedge mclk);
    #1 sw_sleep_req = sleep_req_none;
  endtask : sw_go
  task automatic usb_go;
    @(posedge mclk);
    #1 usb_wake = 1'b1;
    @(posedge mclk);
    #1 usb_wake = 1'b0;
  endtask : usb_go
  initial begin
    #200000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    int n;
    sleep_req_t k;
    void'($urandom(32'h34a5));
    repeat (20) @(posedge mclk);
    #1 nrst = 1'b1;
    cmp_st(st_s5);
    usb_attached = 1'b1;
    usb_go();
    cmp_st(st_s5);
    button_model_inst.hold(Q + 3);
    cmp_st(st_s5);
    button_model_inst.hold(W + 3);
    cmp_st(st_s0);
    button_model_inst.hold($urandom_range(Q - 3, 1));
    cmp_st(st_s0);
    button_model_inst.hold(Q);
    cmp_st(st_s0);
    for (int i = 1; i < 4; i++) begin
      k = sleep_req_t'(i);
      sw_go(k);
      cmp_st(target(k));
      if (k == sleep_req_s5) begin
        button_model_inst.hold(W + 3);
      end else begin
        usb_go();
      end
      cmp_st(st_s0);
    end
    for (int i = 0; i < 3; i++) begin
      button_sleep_cfg = sleep_req_t'(i);
      button_model_inst.hold(Q + 3);
      cmp_st(target(button_sleep_cfg));
      button_model_inst.hold(W - 3);
      cmp_st(target(button_sleep_cfg));
      button_model_inst.hold(W + 3);
      cmp_st(st_s0);
    end
    sw_go(sleep_req_s4);
    usb_attached = 1'b0;
    @(posedge mclk);
    #1 usb_attached = 1'b1;
    usb_go();
    cmp_st(st_s4);
    for (int i = 0; i < 13; i++) begin
      case (i % 3)
        0: n = i < 3 ? Q - 3 : $urandom_range(Q - 3, 1);
        1: n = i < 3 ? Q + 3 : i == 4 ? F - 3 : $urandom_range(F - 3, Q + 3);
        default: n = i < 3 ? F + 3 : $urandom_range(F + 20, F + 3);
      endcase
      // boundary holds around both thresholds
      if (i >= 9) begin
        n = i == 9 ? Q - 1 : i == 10 ? Q : i == 11 ? F - 1 : F;
      end
      reset_pulse_width = 16'($urandom_range(8, 0));
      cnt_clr = 1'b1;
      @(posedge mclk);
      #1 cnt_clr = 1'b0;
      reset_button_model_inst.hold(n);
      repeat (30) @(posedge mclk);
      #1 cmp(mc, rst_cyc(n, 1, reset_pulse_width));
      cmp(sc, rst_cyc(n, 2, reset_pulse_width));
    end
    report_and_stop();
  end
endmodule : button_power_reset_sequencer_test
`default_nettype wire
